// >>> logic/pbc_mdio_slave.sv
// station management frame decoder for the control register
`timescale 1ns/1ns
`default_nettype none
module pbc_mdio_slave (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // management pins
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe_n,
    // register requests
    pbc_req_if.master req
);
    typedef enum logic [2:0] {S_PRE, S_ST, S_HDR, S_TA, S_DATA} pbc_mdio_state_t;

    pbc_mdio_state_t state_r;
    logic mdc_q_r;
    logic mdc_rise;
    logic [5:0] ones_r;
    logic [3:0] bit_r;
    logic [11:0] hdr_r;
    logic [11:0] hdr_nxt;
    logic [15:0] data_r;
    logic rd_hit_r;
    logic wr_hit_r;
    logic addr_hit;
    logic hdr_done;

    assign mdc_rise = i_mdc && !mdc_q_r;
    assign hdr_nxt = {hdr_r[10:0], i_mdio};
    assign hdr_done = mdc_rise && state_r == S_HDR && bit_r == pbc_pkg::HDR_LAST_BIT;
    // port address selects the register set
    assign addr_hit = hdr_nxt[9:5] >= pbc_pkg::PHYAD_FIRST
        && hdr_nxt[9:5] < pbc_pkg::PHYAD_FIRST + 5'(pbc_pkg::NUM_PORTS)
        && hdr_nxt[4:0] == pbc_pkg::REGAD_CTRL;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mdc_q_r <= 1'b0;
        end else if (i_clk_en) begin
            mdc_q_r <= i_mdc;
        end
    end

    // frame sequencing
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r <= S_PRE;
            ones_r <= 6'h00;
            bit_r <= 4'h0;
            hdr_r <= 12'h000;
            rd_hit_r <= 1'b0;
            wr_hit_r <= 1'b0;
        end else if (i_clk_en && mdc_rise) begin
            unique case (state_r)
                S_PRE: begin
                    if (i_mdio) begin
                        if (ones_r != pbc_pkg::PREAMBLE_LEN) begin
                            ones_r <= ones_r + 6'h01;
                        end
                    end else if (ones_r == pbc_pkg::PREAMBLE_LEN) begin
                        state_r <= S_ST;
                    end else begin
                        ones_r <= 6'h00;
                    end
                end
                S_ST: begin
                    ones_r <= 6'h00;
                    bit_r <= 4'h0;
                    state_r <= i_mdio ? S_HDR : S_PRE;
                end
                S_HDR: begin
                    hdr_r <= hdr_nxt;
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == pbc_pkg::HDR_LAST_BIT) begin
                        state_r <= S_TA;
                        bit_r <= 4'h0;
                        rd_hit_r <= addr_hit && hdr_nxt[11:10] == pbc_pkg::OP_READ;
                        wr_hit_r <= addr_hit && hdr_nxt[11:10] == pbc_pkg::OP_WRITE;
                    end
                end
                S_TA: begin
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == pbc_pkg::TA_LAST_BIT) begin
                        state_r <= S_DATA;
                        bit_r <= 4'h0;
                    end
                end
                S_DATA: begin
                    bit_r <= bit_r + 4'h1;
                    if (bit_r == pbc_pkg::DATA_LAST_BIT) begin
                        state_r <= S_PRE;
                        rd_hit_r <= 1'b0;
                        wr_hit_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // data shifter, loaded from the register on a read
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            data_r <= 16'h0000;
        end else if (i_clk_en) begin
            if (req.valid && !req.write) begin
                data_r <= req.rdata;
            end else if (mdc_rise && (state_r == S_DATA || (state_r == S_TA && bit_r != 4'h0))) begin
                data_r <= {data_r[14:0], i_mdio};
            end
        end
    end

    // register requests
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            req.valid <= 1'b0;
            req.write <= 1'b0;
            req.port <= 3'h0;
            req.wdata <= 16'h0000;
        end else if (i_clk_en) begin
            req.valid <= 1'b0;
            if (hdr_done) begin
                req.port <= 3'(hdr_nxt[9:5] - pbc_pkg::PHYAD_FIRST);
                req.valid <= addr_hit && hdr_nxt[11:10] == pbc_pkg::OP_READ;
                req.write <= 1'b0;
            end else if (mdc_rise && state_r == S_DATA && bit_r == pbc_pkg::DATA_LAST_BIT && wr_hit_r) begin
                req.valid <= 1'b1;
                req.write <= 1'b1;
                req.wdata <= {data_r[14:0], i_mdio};
            end
        end
    end

    // pin drive during read turnaround and data
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mdio <= 1'b0;
            o_mdio_oe_n <= 1'b1;
        end else if (i_clk_en && mdc_rise && rd_hit_r) begin
            if (state_r == S_TA && bit_r == 4'h0) begin
                o_mdio_oe_n <= 1'b0;
                o_mdio <= 1'b0;
            end else if (state_r == S_DATA && bit_r == pbc_pkg::DATA_LAST_BIT) begin
                o_mdio_oe_n <= 1'b1;
                o_mdio <= 1'b0;
            end else begin
                o_mdio <= data_r[15];
            end
        end
    end
endmodule : pbc_mdio_slave
`default_nettype wire

// >>> logic/pbc_phy_basic_control.sv
// per-port physical-layer basic control register bank, top level
//
// Behaviour
// - writing one to bit 15 resets the port physical layer; bit self-clears.
// - bit 14 enables MAC loopback at the port's MAC/PHY boundary, default zero.
// - port 1 loopback returns frames from another port out through that port.
// - bit 14 in the register set of port 3, 4 or 5 loops that port.
// - bit 13 forces 100 or 10 Mbit/s; bit 8 forces full or half duplex.
// - bit 12 enables auto-negotiation, default one.
// - writing one to bit 9 restarts auto-negotiation, default zero.
// - bit 11 powers the physical layer down, default zero.
// - bit 10 isolates the physical layer from its transmit pair.
// - bit 5 picks the alternate crossover algorithm when one, default one.
// - bit 3 disables auto crossover; bit 4 forces straight MDI.
// - bit 2 disables far-end-fault detection, default zero.
// - register reachable by station management and serial port, each own mapping.
`timescale 1ns/1ns
`default_nettype none
module pbc_phy_basic_control #(
    parameter int NUM_PORTS = pbc_pkg::NUM_PORTS
) (
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // station management pins
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe_n,
    // serial-port byte access
    input wire logic i_spi_valid,
    input wire logic i_spi_write,
    input wire logic [7:0] i_spi_addr,
    input wire logic [7:0] i_spi_wdata,
    output logic o_spi_ready,
    output logic o_spi_rvalid,
    output logic [7:0] o_spi_rdata,
    // per-port controls to the physical layers and MACs
    output logic [NUM_PORTS-1:0] o_phy_soft_reset,
    output logic [NUM_PORTS-1:0] o_mac_loopback,
    output logic [NUM_PORTS-1:0] o_speed_100,
    output logic [NUM_PORTS-1:0] o_autoneg_enable,
    output logic [NUM_PORTS-1:0] o_autoneg_restart,
    output logic [NUM_PORTS-1:0] o_power_down,
    output logic [NUM_PORTS-1:0] o_phy_isolation,
    output logic [NUM_PORTS-1:0] o_full_duplex,
    output logic [NUM_PORTS-1:0] o_crossover_algorithm_select,
    output logic [NUM_PORTS-1:0] o_force_mdi,
    output logic [NUM_PORTS-1:0] o_crossover_disable,
    output logic [NUM_PORTS-1:0] o_far_end_fault_disable
);
    pbc_req_if mreq ();

    logic [15:0] ctrl_word [NUM_PORTS];
    logic [15:0] rd_word [NUM_PORTS];
    logic [NUM_PORTS-1:0] reserved_seen;
    logic spi_acc;
    logic spi_hit;
    logic [2:0] spi_port;
    logic [7:0] spi_byte;
    logic sel_valid;
    logic sel_write;
    logic [2:0] sel_port;
    logic [1:0] sel_be;
    logic [15:0] sel_wdata;
    logic spi_rvalid_r;
    logic [7:0] spi_rdata_r;

    pbc_mdio_slave u_mdio (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_mdc(i_mdc),
        .i_mdio(i_mdio),
        .o_mdio(o_mdio),
        .o_mdio_oe_n(o_mdio_oe_n),
        .req(mreq.master)
    );

    // serial-port mapping, one slot per port
    assign spi_hit = i_spi_addr[7:4] >= pbc_pkg::SPI_PORT_BASE
        && i_spi_addr[7:4] < pbc_pkg::SPI_PORT_BASE + 4'(NUM_PORTS)
        && i_spi_addr[3:1] == pbc_pkg::SPI_WORD_OFS;
    assign spi_port = 3'(i_spi_addr[7:4] - pbc_pkg::SPI_PORT_BASE);
    assign o_spi_ready = !mreq.valid;
    assign spi_acc = i_spi_valid && o_spi_ready;

    // management frames win a same-cycle collision
    assign sel_valid = mreq.valid || (spi_acc && spi_hit);
    assign sel_write = mreq.valid ? mreq.write : i_spi_write;
    assign sel_port = mreq.valid ? mreq.port : spi_port;
    assign sel_be = mreq.valid ? 2'h3 : (i_spi_addr[0] ? 2'h1 : 2'h2);
    assign sel_wdata = mreq.valid ? mreq.wdata : {i_spi_wdata, i_spi_wdata};
    assign mreq.rdata = rd_word[mreq.port];
    assign spi_byte = spi_hit ? (i_spi_addr[0] ? rd_word[spi_port][7:0] : rd_word[spi_port][15:8])
        : 8'h00;

    // serial-port read answer
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            spi_rvalid_r <= 1'b0;
            spi_rdata_r <= 8'h00;
        end else if (i_clk_en) begin
            spi_rvalid_r <= spi_acc && !i_spi_write;
            if (spi_acc && !i_spi_write) begin
                spi_rdata_r <= spi_byte;
            end
        end
    end

    assign o_spi_rvalid = spi_rvalid_r;
    assign o_spi_rdata = spi_rdata_r;

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        pbc_port_ctrl u_ctrl (
            .i_clk_sys(i_clk_sys),
            .i_reset_n(i_reset_n),
            .i_clk_en(i_clk_en),
            .i_wr(sel_valid && sel_write && sel_port == 3'(p)),
            .i_be(sel_be),
            .i_wdata(sel_wdata),
            .o_ctrl(ctrl_word[p]),
            .o_rdata(rd_word[p]),
            .o_soft_reset(o_phy_soft_reset[p]),
            .o_autoneg_restart(o_autoneg_restart[p])
        );
        // loopback enable to the port datapath
        assign o_mac_loopback[p] = ctrl_word[p][pbc_pkg::BIT_LOOPBACK];
        assign o_speed_100[p] = ctrl_word[p][pbc_pkg::BIT_SPEED_100];
        assign o_full_duplex[p] = ctrl_word[p][pbc_pkg::BIT_FULL_DUPLEX];
        assign o_autoneg_enable[p] = ctrl_word[p][pbc_pkg::BIT_AUTONEG_EN];
        assign o_power_down[p] = ctrl_word[p][pbc_pkg::BIT_POWER_DOWN];
        assign o_phy_isolation[p] = ctrl_word[p][pbc_pkg::BIT_ISOLATE];
        assign o_crossover_algorithm_select[p] = ctrl_word[p][pbc_pkg::BIT_XOVER_ALGO];
        assign o_force_mdi[p] = ctrl_word[p][pbc_pkg::BIT_FORCE_MDI];
        assign o_crossover_disable[p] = ctrl_word[p][pbc_pkg::BIT_XOVER_DISABLE];
        assign o_far_end_fault_disable[p] = ctrl_word[p][pbc_pkg::BIT_FEF_DISABLE];
        assign reserved_seen[p] = |(rd_word[p] & pbc_pkg::CTRL_ZERO_MASK);
    end

    // checks
    logic wr_hi;
    logic wr_lo;
    assign wr_hi = sel_valid && sel_write && sel_be[1] && i_clk_en;
    assign wr_lo = sel_valid && sel_write && sel_be[0] && i_clk_en;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    a_srst_restore:
    assert property (wr_hi && sel_wdata[15] |=> o_phy_soft_reset[$past(sel_port)]
        && ctrl_word[$past(sel_port)] == 16'h3020)
        else $error("soft reset did not pulse or restore defaults");

    a_srst_self_clear:
    assert property ((wr_hi && sel_wdata[15] && sel_port == 3'h0)
        ##1 (i_clk_en && !(wr_hi && sel_wdata[15] && sel_port == 3'h0))
        |=> !o_phy_soft_reset[0])
        else $error("soft reset bit did not self-clear");

    a_loopback_set:
    assert property (wr_hi && !sel_wdata[15]
        |=> o_mac_loopback[$past(sel_port)] == $past(sel_wdata[14]))
        else $error("loopback bit not taken from write");

    a_loopback_mdio:
    assert property (mreq.valid && mreq.write && mreq.port >= 3'h2 && i_clk_en
        && !mreq.wdata[15]
        |=> o_mac_loopback[$past(mreq.port)] == $past(mreq.wdata[14]))
        else $error("management write did not set port loopback");

    a_speed_duplex:
    assert property (wr_hi && wr_lo && !sel_wdata[15]
        |=> o_speed_100[$past(sel_port)] == $past(sel_wdata[13])
        && o_full_duplex[$past(sel_port)] == $past(sel_wdata[8]))
        else $error("forced speed or duplex wrong");

    a_autoneg_enable:
    assert property (wr_hi && !sel_wdata[15]
        |=> o_autoneg_enable[$past(sel_port)] == $past(sel_wdata[12]))
        else $error("negotiation enable wrong");

    a_restart_pulse:
    assert property ((wr_hi && !sel_wdata[15] && sel_wdata[9] && sel_port == 3'h0)
        ##1 (i_clk_en && !wr_hi)
        |-> o_autoneg_restart[0] ##1 !o_autoneg_restart[0])
        else $error("restart is not a one-cycle pulse");

    a_power_down:
    assert property (wr_hi && !sel_wdata[15]
        |=> o_power_down[$past(sel_port)] == $past(sel_wdata[11]))
        else $error("power down bit wrong");

    a_isolation:
    assert property (wr_hi && !sel_wdata[15]
        |=> o_phy_isolation[$past(sel_port)] == $past(sel_wdata[10]))
        else $error("isolation bit wrong");

    a_xover_algo:
    assert property (wr_lo && !(wr_hi && sel_wdata[15])
        |=> o_crossover_algorithm_select[$past(sel_port)] == $past(sel_wdata[5]))
        else $error("crossover algorithm bit wrong");

    a_xover_force:
    assert property (wr_lo && !(wr_hi && sel_wdata[15])
        |=> o_force_mdi[$past(sel_port)] == $past(sel_wdata[4])
        && o_crossover_disable[$past(sel_port)] == $past(sel_wdata[3]))
        else $error("crossover force bits wrong");

    a_fef_disable:
    assert property (wr_lo && !(wr_hi && sel_wdata[15])
        |=> o_far_end_fault_disable[$past(sel_port)] == $past(sel_wdata[2]))
        else $error("far-end-fault disable wrong");

    a_spi_readback:
    assert property (spi_acc && !i_spi_write && i_clk_en && i_spi_addr == 8'h10
        |=> o_spi_rvalid && o_spi_rdata[6] == $past(o_mac_loopback[0])
        && o_spi_rdata[4] == $past(o_autoneg_enable[0]))
        else $error("serial-port readback mismatches register");

    a_reserved_zero:
    assert property (reserved_seen == '0)
        else $error("reserved bits read nonzero");

    a_freeze_hold:
    assert property (!i_clk_en |=> $stable(o_mac_loopback) && $stable(o_autoneg_enable)
        && $stable(o_speed_100) && $stable(o_power_down))
        else $error("controls changed while clock enable low");

    a_rvalid_answer:
    assert property (spi_acc && !i_spi_write && i_clk_en |=> o_spi_rvalid)
        else $error("serial-port read not answered");

    a_rvalid_quiet:
    assert property (i_clk_en && !(spi_acc && !i_spi_write) |=> !o_spi_rvalid)
        else $error("serial-port read answer without request");

    a_spi_unmapped:
    assert property (spi_acc && !i_spi_write && !spi_hit && i_clk_en |=> o_spi_rdata == 8'h00)
        else $error("unmapped serial-port read not zero");

    a_srst_no_restart:
    assert property (wr_hi && sel_wdata[15] |=> !o_autoneg_restart[$past(sel_port)])
        else $error("restart pulsed during soft reset write");

    a_low_keeps_high:
    assert property (wr_lo && !wr_hi
        |=> o_speed_100[$past(sel_port)] == $past(o_speed_100[sel_port])
        && o_full_duplex[$past(sel_port)] == $past(o_full_duplex[sel_port]))
        else $error("low byte write changed high byte fields");

    c_mdio_write: cover property (mreq.valid && mreq.write && i_clk_en);
    c_mdio_read: cover property (mreq.valid && !mreq.write ##[1:1000] !o_mdio_oe_n);
    c_spi_read: cover property (spi_acc && !i_spi_write && spi_hit && i_clk_en);
    c_soft_reset: cover property (o_phy_soft_reset[0]);
    c_loopback_p1: cover property (o_mac_loopback[0]);
endmodule : pbc_phy_basic_control
`default_nettype wire

// >>> logic/pbc_pkg.sv
// shared constants for the per-port basic control register block
package pbc_pkg;
    // port count and physical address mapping on station management
    localparam int NUM_PORTS = 5;
    localparam int PORT_W = 3;
    localparam logic [4:0] PHYAD_FIRST = 5'h01;
    localparam logic [4:0] REGAD_CTRL = 5'h00;

    // station management frame
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] HDR_LAST_BIT = 4'hb;
    localparam logic [3:0] TA_LAST_BIT = 4'h1;
    localparam logic [3:0] DATA_LAST_BIT = 4'hf;

    // byte-wide serial-port mapping: one 16-byte slot per port
    localparam logic [3:0] SPI_PORT_BASE = 4'h1;
    localparam logic [2:0] SPI_WORD_OFS = 3'h0;

    // control register field positions
    localparam int BIT_SOFT_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED_100 = 13;
    localparam int BIT_AUTONEG_EN = 12;
    localparam int BIT_POWER_DOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AUTONEG_RESTART = 9;
    localparam int BIT_FULL_DUPLEX = 8;
    localparam int BIT_XOVER_ALGO = 5;
    localparam int BIT_FORCE_MDI = 4;
    localparam int BIT_XOVER_DISABLE = 3;
    localparam int BIT_FEF_DISABLE = 2;

    // reset value and bits held in flip-flops
    localparam logic [15:0] CTRL_RESET = 16'h3020;
    localparam logic [15:0] CTRL_STORE_MASK = 16'h7d3c;
    localparam logic [15:0] CTRL_ZERO_MASK = 16'h00c3;
endpackage : pbc_pkg

// >>> logic/pbc_port_ctrl.sv
// one port's basic control register with self-clearing command bits
`timescale 1ns/1ns
`default_nettype none
module pbc_port_ctrl (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    // write access
    input wire logic i_wr,
    input wire logic [1:0] i_be,
    input wire logic [15:0] i_wdata,
    // register state
    output logic [15:0] o_ctrl,
    output logic [15:0] o_rdata,
    output logic o_soft_reset,
    output logic o_autoneg_restart
);
    logic [15:0] ctrl_r;
    logic srst_r;
    logic restart_r;
    logic [15:0] wmask;
    logic srst_hit;

    assign wmask = pbc_pkg::CTRL_STORE_MASK & {{8{i_be[1]}}, {8{i_be[0]}}};
    assign srst_hit = i_wr && i_be[1] && i_wdata[pbc_pkg::BIT_SOFT_RESET];

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= pbc_pkg::CTRL_RESET & pbc_pkg::CTRL_STORE_MASK;
        end else if (i_clk_en && srst_hit) begin
            ctrl_r <= pbc_pkg::CTRL_RESET & pbc_pkg::CTRL_STORE_MASK;
        end else if (i_clk_en && i_wr) begin
            ctrl_r <= (ctrl_r & ~wmask) | (i_wdata & wmask);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            srst_r <= 1'b0;
        end else if (i_clk_en) begin
            srst_r <= srst_hit;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            restart_r <= 1'b0;
        end else if (i_clk_en) begin
            restart_r <= i_wr && i_be[1] && !srst_hit && i_wdata[pbc_pkg::BIT_AUTONEG_RESTART];
        end
    end

    assign o_ctrl = ctrl_r;
    assign o_soft_reset = srst_r;
    assign o_autoneg_restart = restart_r;
    assign o_rdata = ctrl_r | {srst_r, 5'h00, restart_r, 9'h000};
endmodule : pbc_port_ctrl
`default_nettype wire

// >>> logic/pbc_req_if.sv
// register request carrier between the management decoder and the register bank
`timescale 1ns/1ns
`default_nettype none
interface pbc_req_if;
    logic valid;
    logic write;
    logic [2:0] port;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport master (output valid, output write, output port, output wdata, input rdata);
    modport slave (input valid, input write, input port, input wdata, output rdata);
endinterface : pbc_req_if
`default_nettype wire

// >>> test/pbc_mdio_host.sv
// management host model driving the station management pins
`timescale 1ns/1ns
`default_nettype none
module pbc_mdio_host (
    // clock
    input wire logic i_clk_sys,
    // device side of the data line
    input wire logic i_mdio,
    input wire logic i_mdio_oe_n,
    // host side
    output logic o_mdc,
    output logic o_mdio
);
    logic drv_en;
    logic drv_val;
    // line pulled up; device drives while its enable is low
    assign o_mdio = !i_mdio_oe_n ? i_mdio : (drv_en ? drv_val : 1'b1);
    initial begin
        o_mdc = 1'b0;
        drv_en = 1'b1;
        drv_val = 1'b1;
    end
    // management path: register 0 of the port address, clock still between frames
    task automatic frame(input logic rd, input logic [4:0] phy, input logic [15:0] wd,
                         output logic [15:0] q);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b01, rd ? pbc_pkg::OP_READ : pbc_pkg::OP_WRITE, phy,
                5'h00, 2'b10, wd};
        q = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            @(posedge i_clk_sys);
            drv_en <= !(rd && i < 18);
            drv_val <= bits[i];
            o_mdc <= 1'b0;
            repeat (4) @(posedge i_clk_sys);
            if (i < 16) q[i] = o_mdio;
            o_mdc <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys);
        o_mdc <= 1'b0;
        drv_en <= 1'b1;
    endtask : frame
endmodule : pbc_mdio_host
`default_nettype wire

// >>> test/pbc_phy_basic_control_tb.sv
// self-checking bench for the basic control register bank
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module pbc_phy_basic_control_tb;
    logic i_clk_sys, i_reset_n, i_clk_en, i_mdc, i_mdio, o_mdio, o_mdio_oe_n;
    logic i_spi_valid, i_spi_write, o_spi_ready, o_spi_rvalid;
    logic [7:0] i_spi_addr, i_spi_wdata, o_spi_rdata;
    logic [4:0] sr, lb, sp, an, ar, pd, iso, fd, xa, fm, xd, fe;
    logic [15:0] exp_w [5];
    logic [15:0] q;
    logic [15:0] w;
    int error_cnt, compares, p;
    pbc_phy_basic_control i_pbc_phy_basic_control (.i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n), .i_clk_en(i_clk_en), .i_mdc(i_mdc), .i_mdio(i_mdio),
        .o_mdio(o_mdio), .o_mdio_oe_n(o_mdio_oe_n), .i_spi_valid(i_spi_valid),
        .i_spi_write(i_spi_write), .i_spi_addr(i_spi_addr), .i_spi_wdata(i_spi_wdata),
        .o_spi_ready(o_spi_ready), .o_spi_rvalid(o_spi_rvalid), .o_spi_rdata(o_spi_rdata),
        .o_phy_soft_reset(sr), .o_mac_loopback(lb), .o_speed_100(sp),
        .o_autoneg_enable(an), .o_autoneg_restart(ar), .o_power_down(pd),
        .o_phy_isolation(iso), .o_full_duplex(fd), .o_crossover_algorithm_select(xa),
        .o_force_mdi(fm), .o_crossover_disable(xd), .o_far_end_fault_disable(fe));
    pbc_mdio_host i_pbc_mdio_host (.i_clk_sys(i_clk_sys), .i_mdio(o_mdio),
        .i_mdio_oe_n(o_mdio_oe_n), .o_mdc(i_mdc), .o_mdio(i_mdio));
    function automatic logic [15:0] apply(logic [15:0] o, logic [15:0] n, logic [1:0] be);
        if (be[1] && n[15]) return 16'h3020;
        if (be[1]) o[15:8] = n[15:8];
        if (be[0]) o[7:0] = n[7:0];
        return o & 16'h7d3c;
    endfunction : apply
    function automatic logic [15:0] got(int i);
        return {1'b0, lb[i], sp[i], an[i], pd[i], iso[i], 1'b0, fd[i], 2'b00, xa[i], fm[i],
                xd[i], fe[i], 2'b00};
    endfunction : got
    task automatic chk_all();
        for (int i = 0; i < 5; i++) `CHK(got(i), exp_w[i])
    endtask : chk_all
    task automatic spi(logic wr, logic [7:0] a, logic [7:0] d);
        @(posedge i_clk_sys);
        i_spi_valid <= 1'b1;
        i_spi_write <= wr;
        i_spi_addr <= a;
        i_spi_wdata <= d;
        @(posedge i_clk_sys);
        while (o_spi_ready !== 1'b1) @(posedge i_clk_sys);
        i_spi_valid <= 1'b0;
        #1;
    endtask : spi
    task automatic rdb(logic [7:0] a, logic [7:0] e);
        spi(1'b0, a, 8'h00);
        `CHK(o_spi_rvalid, 1'b1)
        `CHK(o_spi_rdata, e)
    endtask : rdb
    task automatic wr(int i, logic [15:0] d, logic [1:0] be);
        if (be[1]) begin
            spi(1'b1, 8'(16 * i + 16), d[15:8]);
            `CHK(ar[i], d[9] && !d[15])
            `CHK(sr[i], d[15])
            exp_w[i] = apply(exp_w[i], d, 2'b10);
        end
        if (be[0]) spi(1'b1, 8'(16 * i + 17), d[7:0]);
        exp_w[i] = apply(exp_w[i], d, be & 2'b01);
        chk_all();
        rdb(8'(16 * i + 16), exp_w[i][15:8]);
        rdb(8'(16 * i + 17), exp_w[i][7:0]);
    endtask : wr
    task automatic final_report();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    initial begin
        {i_reset_n, i_spi_valid, i_spi_write, i_spi_addr, i_spi_wdata} = '0;
        i_clk_en = 1'b1;
        for (int i = 0; i < 5; i++) exp_w[i] = 16'h3020;
        void'($urandom(32'haae3fac6));
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        #1;
        chk_all();
        $display("test defaults done");
        for (int b = 2; b < 15; b++) wr(b % 5, 16'(1) << b, 2'b11);
        wr(2, 16'hffff, 2'b10);
        @(posedge i_clk_sys);
        #1;
        `CHK(sr, 5'h00)
        $display("test field sweep done");
        for (int n = 0; n < 30; n++) wr($urandom % 5, 16'($urandom), 2'($urandom_range(1, 3)));
        $display("test random bytes done");
        foreach (w[k]) if (k < 3) spi(1'b1, k == 0 ? 8'h00 : (k == 1 ? 8'h60 : 8'hff), 8'hff);
        chk_all();
        rdb(8'h00, 8'h00);
        rdb(8'h60, 8'h00);
        $display("test unmapped done");
        @(posedge i_clk_sys);
        i_clk_en <= 1'b0;
        spi(1'b1, 8'h10, ~exp_w[0][15:8] & 8'h7d);
        chk_all();
        i_clk_en <= 1'b1;
        $display("test clock enable done");
        for (int n = 0; n < 4; n++) begin
            p = $urandom % 5;
            w = n == 3 ? 16'h8000 : 16'($urandom) & 16'h7fff;
            i_pbc_mdio_host.frame(1'b0, 5'(p + 1), w, q);
            repeat (4) @(posedge i_clk_sys);
            exp_w[p] = apply(exp_w[p], w, 2'b11);
            chk_all();
            i_pbc_mdio_host.frame(1'b1, 5'(p + 1), 16'h0000, q);
            `CHK(q, exp_w[p])
        end
        i_pbc_mdio_host.frame(1'b0, 5'h00, 16'h4800, q);
        i_pbc_mdio_host.frame(1'b1, 5'h06, 16'h0000, q);
        `CHK(q, 16'hffff)
        chk_all();
        $display("test management frames done");
        final_report();
    end
endmodule : pbc_phy_basic_control_tb
`default_nettype wire
